/* File: inc/sleep_pkg.sv */
/*
 * Constants, types and reset image of the sleep and wake sequencer.
 * Assumes a single 25 MHz clock and byte strobes from host-side logic.
 */
package sleep_pkg;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int unsigned CLK_KHZ          = 25000;
   localparam int unsigned BOOT_TIME_MS     = 3500;
   localparam int unsigned BOOT_CYCLES_DFLT = BOOT_TIME_MS * CLK_KHZ;
   localparam int          BOOT_CNT_W       = 27;

   // ***********************************************************
   // Sleep command and wake pattern
   // ***********************************************************
   localparam logic [7:0] SLEEP_B0   = 8'h1b;
   localparam logic [7:0] SLEEP_B1   = 8'hf2;
   localparam logic [7:0] SLEEP_B2   = 8'h02;
   localparam logic [7:0] SLEEP_B3   = 8'h05;
   localparam logic [7:0] SLEEP_PAD  = 8'h00;
   localparam logic [3:0] SEQ_ZERO   = 4'h0;
   localparam logic [3:0] SEQ_ONE    = 4'h1;
   localparam logic [3:0] SEQ_LAST   = 4'h8;
   localparam logic [7:0] NULL_CHAR  = 8'h00;
   localparam logic [2:0] WAKE_ZERO  = 3'h0;
   localparam logic [2:0] WAKE_LAST  = 3'h5;

   // Pin levels assumed before the synchronisers have filled
   localparam logic DTR_IDLE    = 1'b1;
   localparam logic JUMPER_DFLT = 1'b1;
   localparam logic OPT_DFLT    = 1'b1;

   typedef enum logic [1:0] {
      ST_ASLEEP = 2'b00,
      ST_BOOT   = 2'b01,
      ST_RUN    = 2'b10
   } pwr_state_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } byte_strobe_t;

   typedef struct packed {
      logic dtr;
      logic sleep_src;
      logic wake_pat;
      logic opt;
   } pin_sync_t;

   typedef struct packed {
      pin_sync_t             s1;
      pin_sync_t             s2;
      logic                  dtr_prev;
      pwr_state_t            state;
      logic [BOOT_CNT_W-1:0] boot_cnt;
      logic [3:0]            seq_idx;
      logic [2:0]            wake_cnt;
      logic                  main_power;
      logic                  ready;
      logic                  asleep;
   } ctl_state_t;

   localparam pin_sync_t  PINS_RESET = '{DTR_IDLE, JUMPER_DFLT, JUMPER_DFLT, OPT_DFLT};
   localparam ctl_state_t CTL_RESET  = '{PINS_RESET, PINS_RESET, DTR_IDLE, ST_ASLEEP,
                                         '0, SEQ_ZERO, WAKE_ZERO, 1'b0, 1'b0, 1'b1};

   function automatic logic [7:0] sleep_byte(input logic [3:0] idx);
      unique case (idx)
         4'h0:    sleep_byte = SLEEP_B0;
         4'h1:    sleep_byte = SLEEP_B1;
         4'h2:    sleep_byte = SLEEP_B2;
         4'h3:    sleep_byte = SLEEP_B3;
         default: sleep_byte = SLEEP_PAD;
      endcase
   endfunction

endpackage

/* File: logic/printer_sleep_wake_controller.sv */
/*
 * Sleep and wake sequencer of the optional low-power board.
 * Assumes host and serial byte strobes come from logic on mclk; pins and
 * jumpers are asynchronous and are synchronised here.
 */
// Functional notes
// - Power-up always starts asleep, printer unpowered
// - Shorted source jumper: nine-byte command sleeps
// - Without the option the command does nothing
// - Open source jumper: DTR rising sleeps
// - Shorted pattern jumper: six nulls wake
// - Open pattern jumper: any six characters wake
// - DTR low always wakes
// - Ready only after 3.5 s boot interval
// - Asleep removes printer power, wake restores it
`timescale 1ns/1ps

module printer_sleep_wake_controller
   import sleep_pkg::*;
#(
   parameter int unsigned boot_cycles = BOOT_CYCLES_DFLT
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic         dtr_pin,
   input  wire logic         sleep_source_jumper,
   input  wire logic         wake_pattern_jumper,
   input  wire logic         sleep_option_fitted,
   input  wire byte_strobe_t host_byte,
   input  wire byte_strobe_t serial_char,
   output logic              main_power,
   output logic              ready,
   output logic              asleep
);

   // ***********************************************************
   // State
   // ***********************************************************
   ctl_state_t r;
   ctl_state_t next_r;
   logic       dtr_rise;
   logic       char_ok;
   logic       wake_evt;
   logic       seq_match;
   logic       cmd_hit;
   logic       sleep_evt;
   logic       boot_done;

   // Dropped bytes in a partial match restart, but a stray 1b re-arms
   assign dtr_rise  = r.s2.dtr && !r.dtr_prev;
   assign char_ok   = !r.s2.wake_pat || serial_char.data == NULL_CHAR;
   // DTR low, option not fitted or serial pattern; host bytes never wake
   assign wake_evt  = !r.s2.dtr || !r.s2.opt
                      || (serial_char.valid && char_ok && r.wake_cnt == WAKE_LAST);
   assign seq_match = host_byte.data == sleep_byte(r.seq_idx);
   assign cmd_hit   = host_byte.valid && seq_match && r.seq_idx == SEQ_LAST;
   // only a fitted board ever cuts power
   assign sleep_evt = r.s2.opt && (r.s2.sleep_src ? cmd_hit : dtr_rise);
   assign boot_done = r.boot_cnt == BOOT_CNT_W'(boot_cycles - 1);

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb begin
      next_r          = r;
      next_r.s1       = '{dtr_pin, sleep_source_jumper, wake_pattern_jumper,
                          sleep_option_fitted};
      next_r.s2       = r.s1;
      next_r.dtr_prev = r.s2.dtr;
      unique case (r.state)
         ST_ASLEEP: begin
            if (serial_char.valid) begin
               if (char_ok) begin
                  next_r.wake_cnt = 3'(r.wake_cnt + 3'h1);
               end else begin
                  next_r.wake_cnt = WAKE_ZERO;
               end
            end
            if (wake_evt) begin
               next_r.state      = ST_BOOT;
               next_r.boot_cnt   = '0;
               next_r.main_power = 1'b1;
               next_r.asleep     = 1'b0;
               next_r.wake_cnt   = WAKE_ZERO;
            end
         end
         ST_BOOT: begin
            // Sleep requests here are dropped; the printer is still booting
            if (boot_done) begin
               next_r.state = ST_RUN;
               next_r.ready = 1'b1;
            end else begin
               next_r.boot_cnt = BOOT_CNT_W'(r.boot_cnt + 1'b1);
            end
         end
         ST_RUN: begin
            if (host_byte.valid) begin
               if (seq_match && r.seq_idx != SEQ_LAST) begin
                  next_r.seq_idx = 4'(r.seq_idx + SEQ_ONE);
               end else if (host_byte.data == sleep_byte(SEQ_ZERO)) begin
                  next_r.seq_idx = SEQ_ONE;
               end else begin
                  next_r.seq_idx = SEQ_ZERO;
               end
            end
            if (sleep_evt) begin
               next_r.state      = ST_ASLEEP;
               next_r.main_power = 1'b0;
               next_r.ready      = 1'b0;
               next_r.asleep     = 1'b1;
               next_r.seq_idx    = SEQ_ZERO;
               next_r.wake_cnt   = WAKE_ZERO;
            end
         end
         default: begin
            next_r = CTL_RESET;
         end
      endcase
      if (!rst_b) begin
         next_r = CTL_RESET;
      end
   end

   always_ff @(posedge mclk) begin
      r <= next_r;
   end

   assign main_power = r.main_power;
   assign ready      = r.ready;
   assign asleep     = r.asleep;

   // ***********************************************************
   // Checks
   // ***********************************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   sequence s_running;
      r.state == ST_RUN && r.s2.opt;
   endsequence

   sequence s_powered_down;
      asleep && !main_power && !ready;
   endsequence

   sequence s_last_wake_char;
      asleep && r.s2.dtr && serial_char.valid && r.wake_cnt == WAKE_LAST;
   endsequence

   property p_reset_asleep;
      !$past(rst_b) |-> s_powered_down;
   endproperty
   a_reset_asleep: assert property (p_reset_asleep)
      else $error("not asleep after reset");

   property p_cmd_sleep;
      s_running ##0 (r.s2.sleep_src && cmd_hit) |=> s_powered_down;
   endproperty
   a_cmd_sleep: assert property (p_cmd_sleep)
      else $error("sleep command did not sleep");

   property p_no_option;
      (r.state == ST_RUN && !r.s2.opt) |=> !asleep && main_power;
   endproperty
   a_no_option: assert property (p_no_option)
      else $error("slept without sleep option");

   property p_dtr_sleep;
      s_running ##0 (!r.s2.sleep_src && dtr_rise) |=> s_powered_down;
   endproperty
   a_dtr_sleep: assert property (p_dtr_sleep)
      else $error("DTR rise did not sleep");

   property p_null_wake;
      s_last_wake_char ##0 (r.s2.wake_pat && serial_char.data == NULL_CHAR)
         |=> main_power && r.state == ST_BOOT;
   endproperty
   a_null_wake: assert property (p_null_wake)
      else $error("six nulls did not wake");

   property p_any_wake;
      s_last_wake_char ##0 !r.s2.wake_pat |=> main_power && !asleep;
   endproperty
   a_any_wake: assert property (p_any_wake)
      else $error("six characters did not wake");

   property p_dtr_wake;
      (asleep && !r.s2.dtr) |=> main_power ##1 !asleep;
   endproperty
   a_dtr_wake: assert property (p_dtr_wake)
      else $error("DTR low did not wake");

   property p_boot_delay;
      $rose(ready) |-> main_power && $past(r.state) == ST_BOOT && $past(boot_done);
   endproperty
   a_boot_delay: assert property (p_boot_delay)
      else $error("ready before boot interval");

   property p_power_cut;
      asleep |-> !main_power && !ready;
   endproperty
   a_power_cut: assert property (p_power_cut)
      else $error("power on while asleep");

   property p_wake_restart;
      (asleep && r.s2.dtr && serial_char.valid && !char_ok) |=> r.wake_cnt == WAKE_ZERO;
   endproperty
   a_wake_restart: assert property (p_wake_restart)
      else $error("wake count not restarted");

endmodule

/* File: verif/host_model.sv */
/* Host model: drives host bytes, serial chars and DTR.
   Assumes the bench's mclk; byte changes are made at the falling edge, DTR changes when set_dtr is called. */
`timescale 1ns/1ps
module host_model
   import sleep_pkg::*;
(
   input  wire logic   mclk,
   output byte_strobe_t host_byte,
   output byte_strobe_t serial_char,
   output logic         dtr_pin
);
   // DTR is the only handshake line: low wakes, and with the source jumper open its rise sleeps
   initial begin
      host_byte   = '{1'b0, 8'h00};
      serial_char = '{1'b0, 8'h00};
      dtr_pin     = 1'b1;
   end
   // Wake goes over serial or DTR, never USB
   task automatic send_serial(input logic [7:0] ch, input int n);
      repeat (n) begin
         @(negedge mclk);
         serial_char = '{1'b1, ch};
      end
      @(negedge mclk);
      serial_char = '{1'b0, ~ch}; // Stale data inverted so it never matches
   endtask
   task automatic send_host(input logic [7:0] ch);
      @(negedge mclk);
      host_byte = '{1'b1, ch};
      @(negedge mclk);
      host_byte = '{1'b0, ~ch};
   endtask
   task automatic send_cmd();
      logic [7:0] seq [9] = '{8'h1b, 8'hf2, 8'h02, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      foreach (seq[i]) begin
         @(negedge mclk);
         host_byte = '{1'b1, seq[i]};
      end
      @(negedge mclk);
      host_byte = '{1'b0, 8'hff};
   endtask
   task automatic set_dtr(input logic v);
      dtr_pin = v;
   endtask
endmodule

/* File: verif/tb_top.sv */
/* Self-checking bench of the sleep and wake sequencer.
   Assumes a short boot count; host_model stands in for the host. */
`timescale 1ns/1ps
module tb_top
   import sleep_pkg::*;
();
   // ************************************************
   // Bench signals
   // ************************************************
   localparam int BOOT = 20; // Short boot keeps the run brief
   typedef struct {logic src; logic pat; logic [1:0] kind; logic [7:0] ch; logic exp;} row_t;
   logic         mclk;
   logic         rst_b;
   logic         src_j;
   logic         pat_j;
   logic         opt;
   byte_strobe_t host_byte;
   byte_strobe_t serial_char;
   logic         dtr_pin;
   logic         main_power;
   logic         ready;
   logic         asleep;
   int           num_errors = 0;
   int           cmp_count = 0;
   // Kind: 0 six serial chars, 1 command, 2 DTR low then high, 3 DTR low
   row_t rows [7] = '{'{1, 1, 0, 8'h00, 0}, '{1, 1, 1, 8'h00, 1}, '{1, 0, 0, 8'h41, 0},
                      '{0, 0, 2, 8'h00, 1}, '{0, 0, 3, 8'h00, 0}, '{1, 1, 2, 8'h00, 0},
                      '{1, 1, 1, 8'h00, 1}};
   // Broken at the fourth byte, so the trailing zeros must not complete it
   logic [7:0]   bad_cmd [9] = '{8'h1b, 8'hf2, 8'h02, 8'h41, 8'h00, 8'h00, 8'h00, 8'h00,
                                 8'h00};
   host_model hm (.mclk(mclk), .host_byte(host_byte), .serial_char(serial_char),
                  .dtr_pin(dtr_pin));
   printer_sleep_wake_controller #(.boot_cycles(BOOT)) uut (.mclk(mclk), .rst_b(rst_b),
      .dtr_pin(dtr_pin), .sleep_source_jumper(src_j), .wake_pattern_jumper(pat_j),
      .sleep_option_fitted(opt), .host_byte(host_byte), .serial_char(serial_char),
      .main_power(main_power), .ready(ready), .asleep(asleep));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // ************************************************
   // Tasks
   // ************************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Must start at the first falling edge after main_power rose
   task automatic wait_ready();
      int n = 0;
      while (ready !== 1'b1) begin
         @(negedge mclk);
         n++;
         if (n > 3 * BOOT) begin
            num_errors++;
            end_of_test();
         end
      end
      check("boot cycles", n, BOOT);
   endtask
   task automatic settle(input logic exp);
      for (int i = 0; i < 6 && asleep !== exp; i++)
         @(negedge mclk);
      check("asleep", asleep, exp);
      check("main_power", main_power, !exp);
      if (exp === 1'b0 && ready !== 1'b1)
         wait_ready();
   endtask
   task automatic run_row(input row_t r);
      src_j = r.src;
      pat_j = r.pat;
      repeat (3) @(negedge mclk);
      case (r.kind)
         2'h0: hm.send_serial(r.ch, 6);
         2'h1: hm.send_cmd();
         2'h2: begin
            hm.set_dtr(1'b0);
            repeat (4) @(negedge mclk);
            hm.set_dtr(1'b1);
         end
         default: hm.set_dtr(1'b0);
      endcase
      settle(r.exp);
   endtask
   // ************************************************
   // Sequence
   // ************************************************
   initial begin
      rst_b = 1'b0;
      src_j = 1'b1;
      pat_j = 1'b1;
      opt = 1'b1;
      repeat (6) @(negedge mclk);
      check("power in reset", main_power, 0);
      rst_b = 1'b1;
      repeat (8) @(negedge mclk);
      check("asleep after reset", asleep, 1);
      $display("Test reset done");
      foreach (rows[i]) begin
         run_row(rows[i]);
         $display("Test row %0d done", i);
      end
      for (int i = 0; i < 6; i++)
         hm.send_host(8'h00);
      repeat (4) @(negedge mclk);
      check("usb no wake", asleep, 1);
      hm.send_serial(8'h00, 5);
      hm.send_serial(8'h41, 1);
      hm.send_serial(8'h00, 5);
      repeat (4) @(negedge mclk);
      check("broken run", asleep, 1);
      hm.send_serial(8'h00, 1);
      settle(1'b0);
      hm.send_serial(8'h00, 3);
      hm.send_cmd();
      settle(1'b1);
      hm.send_serial(8'h00, 5);
      repeat (4) @(negedge mclk);
      check("count cleared", asleep, 1);
      hm.send_serial(8'h00, 1);
      settle(1'b0);
      $display("Test wake count done");
      foreach (bad_cmd[i])
         hm.send_host(bad_cmd[i]);
      check("broken command", asleep, 0);
      hm.send_host(8'h1b);
      hm.send_host(8'hf2);
      hm.send_cmd();
      settle(1'b1);
      $display("Test command match done");
      opt = 1'b0;
      repeat (3) @(negedge mclk);
      settle(1'b0);
      hm.send_cmd();
      repeat (4) @(negedge mclk);
      check("no option", asleep, 0);
      rst_b = 1'b0;
      repeat (2) @(negedge mclk);
      check("asleep mid reset", asleep, 1);
      check("ready mid reset", ready, 0);
      $display("Test option and reset done");
      end_of_test();
   end
endmodule
